// ==== dozc_pkg.sv ====
// dozc_pkg: constants, types and helpers for the termination / calibration block.
// assumes one core clock at 200 MHz and a link clock driven by the memory controller.
//
// How it works
// - use async termination while DLL-on but frozen in precharge power-down (A12 clear).
// - async termination follows the ODT pin directly, no additive latency.
// - async turn-on/turn-off land inside the async on/off delay windows.
// - with A12 clear, power-down entry has a sync-or-async transition period.
// - lead interval is write latency minus one, around CKE registered low/high; the code checks it only before CKE registered low.
// - entry period excludes lead start, includes end of CKE-low command delay.
// - refresh in progress stretches entry period to later of refresh end and delay end.
// - assertion in transition may land between smaller minimum and larger maximum.
// - deassertion in entry transition may land between smaller minimum and larger maximum.
// - exit period runs from CKE registered high to DLL exit delay after.
// - overlapping entry and exit periods merge into one uncertain span.
// - long calibration recalibrates driver and termination, then loads the I/O.
// - first long calibration after reset gets initial time, later ones operational time.
// - short calibration corrects drift and finishes within the short time.
// - calibration current path switches off once calibration is done.
// - no recalibration after self-refresh exit without an explicit command.
// - termination is off and data bus idle during calibration.
// - sync termination latency is write latency (cwl plus additive latency) minus two.
package dozc_pkg;

  // core clock period and time figures, in their own units
  localparam int CORE_PERIOD_PS = 5000;
  localparam int AON_PD_MIN_NS  = 2;
  localparam int AOF_PD_MIN_NS  = 2;
  localparam int INIT_CAL_NS    = 640;
  localparam int OPER_CAL_NS    = 320;
  localparam int SHORT_CAL_NS   = 80;

  // link-side counts in link clock cycles; CNT_W is a counter width in bits
  localparam int CPDED_CK_DEF   = 1;
  localparam int RFC_CK_DEF     = 208;
  localparam int XPDLL_CK_DEF   = 24;
  localparam int ODTL_OFFSET    = 2;
  localparam int LEAD_OFFSET    = 1;
  localparam int HIST_DEPTH     = 32;
  localparam int CNT_W          = 16;

  // least times round up
  function automatic int ns_ceil_cyc(input int ns);
    int c;
    c = (ns * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : ns_ceil_cyc

  // longest times round down
  function automatic int ns_floor_cyc(input int ns);
    int c;
    c = (ns * 1000) / CORE_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : ns_floor_cyc

  // write latency = cwl + al
  function automatic logic [4:0] wl_sum(input logic [3:0] cwl_v, input logic [3:0] al_v);
    return {1'h0, cwl_v} + {1'h0, al_v};
  endfunction : wl_sum

  // clamped subtraction on a 5-bit latency
  function automatic logic [4:0] lat_minus(input logic [4:0] lat, input int sub);
    logic [4:0] s;
    s = 5'(sub);
    return (lat > s) ? lat - s : 5'h00;
  endfunction : lat_minus

  typedef enum logic [3:0] {
    PD_ACTIVE = 4'h1,
    PD_ENTRY  = 4'h2,
    PD_FROZEN = 4'h4,
    PD_EXIT   = 4'h8
  } dozc_pd_state_t;

  typedef enum logic [2:0] {
    CAL_IDLE  = 3'h1,
    CAL_LONG  = 3'h2,
    CAL_SHORT = 3'h4
  } dozc_cal_state_t;

  // decoded commands registered on the link clock
  typedef struct packed {
    logic zqcl;
    logic zqcs;
    logic refresh;
  } dozc_cmd_t;

  typedef struct packed {
    logic rtt_en;
    logic zq_path_en;
    logic io_cal_load;
  } dozc_term_t;

  typedef struct packed {
    logic cal_busy;
    logic term_async;
    logic odt_mode_uncertain;
    logic lead_change;
  } dozc_status_t;

endpackage : dozc_pkg

// ==== dozc_sync.sv ====
// dozc_sync: two-flop level synchroniser, one bit per lane.
// assumes each lane is an independent level; multi-bit words must not pass here.
`timescale 1ns/1ps
module dozc_sync #(
  parameter int W = 1
) (
  // destination domain
  input  wire logic         clk,
  input  wire logic         rst,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // first stage is read only by the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : dozc_sync

// ==== dozc_top.sv ====
// dozc_top: termination timing across frozen-DLL power-down and ZQ calibration engine.
// assumes cke, odt and cmd arrive on link_clk edges; mode fields are stable link-side levels.
`timescale 1ns/1ps
module dozc_top
  import dozc_pkg::*;
#(
  parameter int INIT_CAL_CYC  = ns_floor_cyc(INIT_CAL_NS),
  parameter int OPER_CAL_CYC  = ns_floor_cyc(OPER_CAL_NS),
  parameter int SHORT_CAL_CYC = ns_floor_cyc(SHORT_CAL_NS),
  parameter int CPDED_CK      = CPDED_CK_DEF,
  parameter int RFC_CK        = RFC_CK_DEF,
  parameter int XPDLL_CK      = XPDLL_CK_DEF
) (
  // core clock and reset
  input  wire logic         core_clk,
  input  wire logic         srst,
  // link from the controller
  input  wire logic         link_clk,
  input  wire logic         cke,
  input  wire logic         odt,
  input  wire dozc_cmd_t    cmd,
  // mode register fields
  input  wire logic [3:0]   cwl,
  input  wire logic [3:0]   al,
  input  wire logic         ppd_dll_on,
  // termination and calibration outputs
  output dozc_term_t        term,
  output dozc_status_t      status
);

  localparam int AON_CYC = ns_ceil_cyc(AON_PD_MIN_NS);
  localparam int AOF_CYC = ns_ceil_cyc(AOF_PD_MIN_NS);
  localparam int ASYNC_MAX = (AON_CYC > AOF_CYC) ? AON_CYC : AOF_CYC;
  localparam int SYNC_W  = 7;

  // ---------------- link domain ----------------
  logic                  link_rst;
  logic                  cke_q;
  logic                  odt_q;
  dozc_cmd_t             cmd_q;
  logic [HIST_DEPTH-1:0] odt_hist;
  logic                  sync_rtt;
  dozc_pd_state_t        pd_state;
  logic [CNT_W-1:0]      cpded_cnt;
  logic [CNT_W-1:0]      rfc_cnt;
  logic [CNT_W-1:0]      xpdll_cnt;
  logic [4:0]            odt_quiet;
  logic                  lead_change;
  logic                  zqcl_tgl;
  logic                  zqcs_tgl;
  logic [4:0]            odtl_idx;
  logic [4:0]            lead_len;
  logic                  async_l;
  logic                  unc_l;

  // reset reaches the link side through its own synchroniser
  dozc_sync #(.W(1)) u_rst_sync (
    .clk (link_clk),
    .rst (1'h0),
    .d   (srst),
    .q   (link_rst)
  );

  assign odtl_idx = lat_minus(wl_sum(cwl, al), ODTL_OFFSET + ODTL_OFFSET);
  assign lead_len = lat_minus(wl_sum(cwl, al), LEAD_OFFSET);

  // pins are already on link_clk; this is the registration edge
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      cke_q <= 1'h0;
      odt_q <= 1'h0;
      cmd_q <= '0;
    end else begin
      cke_q <= cke;
      odt_q <= odt;
      cmd_q <= cmd;
    end
  end

  // sync path carries the additive latency; the async path never does
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      odt_hist <= '0;
      sync_rtt <= 1'h0;
    end else begin
      odt_hist <= {odt_hist[HIST_DEPTH-2:0], odt_q};
      sync_rtt <= odt_hist[odtl_idx];
    end
  end

  // refresh in flight keeps the entry period open
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      rfc_cnt <= '0;
    end else if (cmd_q.refresh) begin
      rfc_cnt <= CNT_W'(RFC_CK - 1);
    end else if (rfc_cnt != '0) begin
      rfc_cnt <= rfc_cnt - 1'h1;
    end
  end

  // cycles since odt last moved, saturating at 31
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      odt_quiet <= 5'h1F;
    end else if (odt != odt_q) begin
      odt_quiet <= 5'h00;
    end else if (odt_quiet != 5'h1F) begin
      odt_quiet <= odt_quiet + 5'h01;
    end
  end

  // power-down tracking; dll-on power-down (A12 set) stays synchronous
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      pd_state    <= PD_ACTIVE;
      cpded_cnt   <= '0;
      xpdll_cnt   <= '0;
      lead_change <= 1'h0;
    end else begin
      case (pd_state)
        PD_ACTIVE: begin
          lead_change <= 1'h0;
          if (!cke_q && !ppd_dll_on) begin
            pd_state    <= PD_ENTRY;
            cpded_cnt   <= CNT_W'(CPDED_CK - 1);
            // odt moved inside the lead before cke fell: response is uncertain
            lead_change <= (odt_quiet < lead_len);
          end
        end
        PD_ENTRY: begin
          if (cke_q) begin
            pd_state  <= PD_EXIT;
            xpdll_cnt <= CNT_W'(XPDLL_CK - 1);
          end else if (cpded_cnt == '0 && rfc_cnt == '0) begin
            pd_state <= PD_FROZEN;
          end else if (cpded_cnt != '0) begin
            cpded_cnt <= cpded_cnt - 1'h1;
          end
        end
        PD_FROZEN: begin
          if (cke_q) begin
            pd_state  <= PD_EXIT;
            xpdll_cnt <= CNT_W'(XPDLL_CK - 1);
          end
        end
        PD_EXIT: begin
          if (!cke_q) begin
            pd_state  <= PD_ENTRY;
            cpded_cnt <= CNT_W'(CPDED_CK - 1);
          end else if (xpdll_cnt == '0) begin
            pd_state <= PD_ACTIVE;
          end else begin
            xpdll_cnt <= xpdll_cnt - 1'h1;
          end
        end
        default: begin
          pd_state <= PD_ACTIVE;
        end
      endcase
    end
  end

  // calibration commands become toggles for the crossing
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      zqcl_tgl <= 1'h0;
      zqcs_tgl <= 1'h0;
    end else begin
      zqcl_tgl <= zqcl_tgl ^ cmd_q.zqcl;
      zqcs_tgl <= zqcs_tgl ^ cmd_q.zqcs;
    end
  end

  // flags leave the link side from flops; a state decode could glitch into the sync
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      async_l <= 1'h0;
      unc_l   <= 1'h0;
    end else begin
      async_l <= (pd_state == PD_FROZEN) || (pd_state == PD_EXIT);
      unc_l   <= (pd_state == PD_ENTRY) || (pd_state == PD_EXIT);
    end
  end

  // ---------------- crossing ----------------
  logic [SYNC_W-1:0] to_core;
  logic [SYNC_W-1:0] from_link;
  logic              zqcl_tgl_s;
  logic              zqcs_tgl_s;
  logic              term_async_s;
  logic              uncertain_s;
  logic              sync_rtt_s;
  logic              lead_change_s;
  logic              odt_s;

  // odt pin goes raw to the core side for the async path
  assign to_core = {zqcl_tgl, zqcs_tgl, async_l, unc_l, sync_rtt, lead_change, odt};

  dozc_sync #(.W(SYNC_W)) u_link_sync (
    .clk (core_clk),
    .rst (srst),
    .d   (to_core),
    .q   (from_link)
  );

  assign {zqcl_tgl_s, zqcs_tgl_s, term_async_s, uncertain_s,
          sync_rtt_s, lead_change_s, odt_s} = from_link;

  // ---------------- core domain ----------------
  logic             zqcl_prev;
  logic             zqcs_prev;
  logic             zqcl_evt;
  logic             zqcs_evt;
  dozc_cal_state_t  cal_state;
  logic [CNT_W-1:0] cal_cnt;
  logic             first_done;
  logic             async_rtt;
  logic [CNT_W-1:0] async_cnt;
  logic             cal_active;

  assign zqcl_evt   = zqcl_tgl_s ^ zqcl_prev;
  assign zqcs_evt   = zqcs_tgl_s ^ zqcs_prev;
  assign cal_active = (cal_state != CAL_IDLE);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      zqcl_prev <= 1'h0;
      zqcs_prev <= 1'h0;
    end else begin
      zqcl_prev <= zqcl_tgl_s;
      zqcs_prev <= zqcs_tgl_s;
    end
  end

  // only an explicit command starts calibration, self-refresh exit included
  // commands arriving while busy are dropped: the channel must be quiet then
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cal_state  <= CAL_IDLE;
      cal_cnt    <= '0;
      first_done <= 1'h0;
    end else begin
      case (cal_state)
        CAL_IDLE: begin
          if (zqcl_evt) begin
            cal_state  <= CAL_LONG;
            first_done <= 1'h1;
            cal_cnt    <= first_done ? CNT_W'(OPER_CAL_CYC - 1)
                                     : CNT_W'(INIT_CAL_CYC - 1);
          end else if (zqcs_evt) begin
            cal_state <= CAL_SHORT;
            cal_cnt   <= CNT_W'(SHORT_CAL_CYC - 1);
          end
        end
        CAL_LONG, CAL_SHORT: begin
          if (cal_cnt == '0) begin
            cal_state <= CAL_IDLE;
          end else begin
            cal_cnt <= cal_cnt - 1'h1;
          end
        end
        default: begin
          cal_state <= CAL_IDLE;
        end
      endcase
    end
  end

  // async termination: pin level applied after the async delay, no latency pipe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      async_rtt <= 1'h0;
      async_cnt <= '0;
    end else if (odt_s == async_rtt) begin
      async_cnt <= '0;
    end else if (async_cnt >= CNT_W'((odt_s ? AON_CYC : AOF_CYC) - 1)) begin
      async_rtt <= odt_s;
      async_cnt <= '0;
    end else begin
      async_cnt <= async_cnt + 1'h1;
    end
  end

  // outputs; in transition either response is allowed, so entry keeps sync
  // and exit keeps async until the dll has relocked
  always_ff @(posedge core_clk) begin
    if (srst) begin
      term <= '0;
    end else begin
      if (cal_active) begin
        term.rtt_en <= 1'h0;
      end else if (term_async_s) begin
        term.rtt_en <= async_rtt;
      end else begin
        term.rtt_en <= sync_rtt_s;
      end
      term.zq_path_en  <= cal_active && (cal_cnt != '0);
      term.io_cal_load <= cal_active && (cal_cnt == '0);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      status <= '0;
    end else begin
      status.cal_busy           <= cal_active;
      status.term_async         <= term_async_s;
      status.odt_mode_uncertain <= uncertain_s || lead_change_s;
      status.lead_change        <= lead_change_s;
    end
  end

  // ---------------- checks ----------------
  sequence s_cal_end;
    cal_active && (cal_cnt == '0);
  endsequence

  sequence s_load_pulse;
    term.io_cal_load ##1 !term.io_cal_load;
  endsequence

  chk_rtt_off_cal: assert property (@(posedge core_clk) disable iff (srst)
    cal_active |=> !term.rtt_en)
    else $error("termination on during calibration");

  chk_init_cal_time: assert property (@(posedge core_clk) disable iff (srst)
    (cal_state == CAL_IDLE) && zqcl_evt && !first_done
      |=> (cal_state == CAL_LONG) && (cal_cnt == CNT_W'(INIT_CAL_CYC - 1)))
    else $error("first long calibration not given initial time");

  chk_oper_cal_time: assert property (@(posedge core_clk) disable iff (srst)
    (cal_state == CAL_IDLE) && zqcl_evt && first_done
      |=> (cal_state == CAL_LONG) && (cal_cnt == CNT_W'(OPER_CAL_CYC - 1)))
    else $error("later long calibration not given operational time");

  chk_short_cal_time: assert property (@(posedge core_clk) disable iff (srst)
    (cal_state == CAL_IDLE) && zqcs_evt && !zqcl_evt
      |=> (cal_state == CAL_SHORT) && (cal_cnt == CNT_W'(SHORT_CAL_CYC - 1)))
    else $error("short calibration length wrong");

  chk_cal_load_once: assert property (@(posedge core_clk) disable iff (srst)
    s_cal_end |=> s_load_pulse)
    else $error("calibrated values not loaded once at the end");

  chk_zq_path_off: assert property (@(posedge core_clk) disable iff (srst)
    term.io_cal_load |-> !term.zq_path_en ##1 !term.zq_path_en)
    else $error("calibration current path left on");

  chk_async_follow: assert property (@(posedge core_clk) disable iff (srst)
    (odt_s != async_rtt) |-> ##[0:ASYNC_MAX] (odt_s == async_rtt))
    else $error("async termination missed its delay window");

  chk_entry_freeze: assert property (@(posedge link_clk) disable iff (link_rst)
    (pd_state == PD_ENTRY) && !cke_q && (cpded_cnt == '0) && (rfc_cnt == '0)
      |=> (pd_state == PD_FROZEN))
    else $error("entry period did not end at command delay");

  chk_refresh_hold: assert property (@(posedge link_clk) disable iff (link_rst)
    (pd_state == PD_ENTRY) && !cke_q && (rfc_cnt != '0) |=> (pd_state == PD_ENTRY))
    else $error("entry period ended during refresh");

  chk_exit_period: assert property (@(posedge link_clk) disable iff (link_rst)
    (pd_state == PD_FROZEN) && cke_q
      |=> (pd_state == PD_EXIT) && (xpdll_cnt == CNT_W'(XPDLL_CK - 1)))
    else $error("exit period not started on cke high");

  chk_dll_on_sync: assert property (@(posedge link_clk) disable iff (link_rst)
    (pd_state == PD_ACTIVE) && ppd_dll_on |=> (pd_state == PD_ACTIVE))
    else $error("async mode entered with dll kept on");

endmodule : dozc_top

// ==== dozc_ctrl_model.sv ====
// dozc_ctrl_model: behavioural memory controller driving cke, odt and decoded commands.
// assumes link_clk comes from the bench; every change lands on a falling link edge.
`timescale 1ns/1ps
module dozc_ctrl_model
  import dozc_pkg::*;
#(
  parameter int XS_CK    = 6,
  parameter int QUIET_CK = 14
) (
  // link clock
  input  wire logic link_clk,
  // controller drive
  output logic      cke,
  output logic      odt,
  output dozc_cmd_t cmd
);
  int up_cnt;

  initial begin
    cke    = 1'h1;
    odt    = 1'h0;
    cmd    = '0;
    up_cnt = 0;
  end

  always @(posedge link_clk) up_cnt <= cke ? up_cnt + 1 : 0;

  // odt moves only on request, so a scenario owns any change inside a transition
  task automatic set_odt(input logic v);
    @(negedge link_clk);
    odt = v;
  endtask : set_odt

  task automatic set_cke(input logic v);
    @(negedge link_clk);
    cke = v;
  endtask : set_cke

  // no activates exist here, so banks are always closed and precharged
  task automatic issue(input dozc_cmd_t c);
    @(negedge link_clk);
    cmd = c;
    @(negedge link_clk);
    cmd = '0;
  endtask : issue

  // odt_off low is a deliberate fault, used to show termination forced off
  task automatic zq(input logic long_cal, input logic odt_off);
    @(negedge link_clk);
    if (odt_off) odt = 1'h0;
    while (up_cnt < XS_CK) @(negedge link_clk);
    issue(long_cal ? 3'h4 : 3'h2);
    repeat (QUIET_CK) @(negedge link_clk);
  endtask : zq
endmodule : dozc_ctrl_model

// ==== tb.sv ====
// tb: self-checking bench for dozc_top with a behavioural controller on the link.
// assumes lengthened calibration and shortened refresh counts below; link clock runs free.
`timescale 1ns/1ps
module tb
  import dozc_pkg::*;
;
  localparam int INIT_C  = 320;
  localparam int OPER_C  = 224;
  localparam int SHORT_C = 24;
  localparam int XPDLL_C = 4;
  localparam int LINK_C  = 32;
  localparam int CPDED_C = 3;

  logic         core_clk    = 1'h0;
  logic         link_clk    = 1'h0;
  logic         srst        = 1'h1;
  logic         cke;
  logic         odt;
  dozc_cmd_t    cmd;
  logic [3:0]   cwl         = 4'h5;
  logic [3:0]   al          = 4'h0;
  logic         ppd_dll_on  = 1'h1;
  dozc_term_t   term;
  dozc_status_t status;
  int           mismatches  = 0;
  int           checks_done = 0;
  int           cycles      = 0;

  always #2.5 core_clk = ~core_clk;

  // unrelated phase to the core clock
  initial begin
    #1.3;
    forever #80 link_clk = ~link_clk;
  end

  dozc_top #(
    .INIT_CAL_CYC  (INIT_C),
    .OPER_CAL_CYC  (OPER_C),
    .SHORT_CAL_CYC (SHORT_C),
    .CPDED_CK      (CPDED_C),
    .RFC_CK        (6),
    .XPDLL_CK      (XPDLL_C)
  ) u_dozc_top (
    .core_clk   (core_clk),
    .srst       (srst),
    .link_clk   (link_clk),
    .cke        (cke),
    .odt        (odt),
    .cmd        (cmd),
    .cwl        (cwl),
    .al         (al),
    .ppd_dll_on (ppd_dll_on),
    .term       (term),
    .status     (status)
  );

  dozc_ctrl_model u_dozc_ctrl_model (
    .link_clk (link_clk),
    .cke      (cke),
    .odt      (odt),
    .cmd      (cmd)
  );

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("unexpected %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_rng

  task automatic links(input int n);
    repeat (n) @(negedge link_clk);
  endtask : links

  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (status.cal_busy !== v && n < 600) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_busy

  task automatic wait_rtt(input logic v, output int n);
    n = 0;
    while (term.rtt_en !== v && n < 400) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_rtt

  // counts core cycles in the window that show the uncertain flag at level v
  task automatic count_unc(input logic v, input int win, output int n);
    n = 0;
    repeat (win) begin
      @(negedge core_clk);
      n += (status.odt_mode_uncertain === v);
    end
  endtask : count_unc

  task automatic cal_run(input logic long_cal, input int lo, input logic odt_off);
    int n;
    int loads;
    int rtt_on;
    n      = 0;
    loads  = 0;
    rtt_on = 0;
    fork
      u_dozc_ctrl_model.zq(long_cal, odt_off);
    join_none
    wait_busy(1'h1);
    chk("zq path on", 1'h1, term.zq_path_en);
    while (status.cal_busy === 1'h1 && n < 600) begin
      loads += (term.io_cal_load === 1'h1);
      rtt_on += (term.rtt_en === 1'h1);
      @(negedge core_clk);
      n++;
    end
    loads += (term.io_cal_load === 1'h1);
    chk_rng("cal time", lo, lo + 3, n);
    chk("io load pulses", 1, loads);
    chk("rtt during cal", 0, rtt_on);
    chk("zq path off", 1'h0, term.zq_path_en);
    wait fork;
  endtask : cal_run

  task automatic t_refuse;
    int n;
    fork
      u_dozc_ctrl_model.zq(1'h1, 1'h1);
    join_none
    wait_busy(1'h1);
    u_dozc_ctrl_model.issue(3'h2);
    wait_busy(1'h0);
    n = 0;
    repeat (160) begin
      @(negedge core_clk);
      n += (status.cal_busy === 1'h1);
    end
    chk("busy after refused", 0, n);
    wait fork;
  endtask : t_refuse

  task automatic t_sync(input logic [3:0] cwl_v, input logic [3:0] al_v);
    int n;
    int c;
    @(negedge core_clk);
    cwl = cwl_v;
    al  = al_v;
    c   = LINK_C / 2 + (cwl_v + al_v - 2) * LINK_C;
    links(4);
    u_dozc_ctrl_model.set_odt(1'h1);
    wait_rtt(1'h1, n);
    chk_rng("sync on", c - 4, c + 10, n);
    u_dozc_ctrl_model.set_odt(1'h0);
    wait_rtt(1'h0, n);
    chk_rng("sync off", c - 4, c + 10, n);
    links(4);
  endtask : t_sync

  task automatic t_pd;
    int n;
    u_dozc_ctrl_model.set_cke(1'h0);
    links(6);
    chk("dll kept on", 1'h0, status.term_async);
    u_dozc_ctrl_model.set_cke(1'h1);
    @(negedge core_clk);
    ppd_dll_on = 1'h0;
    links(6);
    u_dozc_ctrl_model.set_cke(1'h0);
    links(10);
    chk("async mode", 1'h1, status.term_async);
    chk("entry over", 1'h0, status.odt_mode_uncertain);
    chk("no lead", 1'h0, status.lead_change);
    u_dozc_ctrl_model.set_odt(1'h1);
    wait_rtt(1'h1, n);
    chk_rng("async on", 1, 10, n);
    u_dozc_ctrl_model.set_odt(1'h0);
    wait_rtt(1'h0, n);
    chk_rng("async off", 1, 10, n);
    u_dozc_ctrl_model.set_cke(1'h1);
    links(3);
    chk("exit window", 1'h1, status.odt_mode_uncertain);
    links(XPDLL_C + 6);
    chk("sync again", 1'h0, status.term_async);
    chk("no self cal", 1'h0, status.cal_busy);
  endtask : t_pd

  task automatic t_entry(input logic with_ref, input int lo, input int hi);
    int n;
    if (with_ref) u_dozc_ctrl_model.issue(3'h1);
    u_dozc_ctrl_model.set_cke(1'h0);
    count_unc(1'h1, 8 * LINK_C, n);
    chk_rng("entry period", lo, hi, n);
    u_dozc_ctrl_model.set_cke(1'h1);
    links(XPDLL_C + 6);
  endtask : t_entry

  task automatic t_lead;
    int n;
    u_dozc_ctrl_model.set_cke(1'h0);
    links(6);
    u_dozc_ctrl_model.set_cke(1'h1);
    u_dozc_ctrl_model.set_cke(1'h0);
    links(2);
    count_unc(1'h0, LINK_C + 8, n);
    chk("overlap gap", 0, n);
    u_dozc_ctrl_model.set_cke(1'h1);
    links(XPDLL_C + 6);
    u_dozc_ctrl_model.set_odt(1'h1);
    u_dozc_ctrl_model.set_cke(1'h0);
    links(8);
    chk("lead change", 1'h1, status.lead_change);
    u_dozc_ctrl_model.set_cke(1'h1);
    links(XPDLL_C + 8);
    chk("lead cleared", 1'h0, status.lead_change);
    u_dozc_ctrl_model.set_odt(1'h0);
    links(8);
  endtask : t_lead

  initial begin
    repeat (12) @(negedge core_clk);
    repeat (3) @(posedge link_clk);
    @(negedge core_clk);
    chk("term in reset", 0, term);
    chk("status in reset", 0, status);
    srst = 1'h0;
    links(4);
    cal_run(1'h1, INIT_C, 1'h1);
    cal_run(1'h1, OPER_C, 1'h1);
    u_dozc_ctrl_model.set_odt(1'h1);
    cal_run(1'h0, SHORT_C, 1'h0);
    u_dozc_ctrl_model.set_odt(1'h0);
    links(8);
    t_refuse();
    t_sync(4'h6, 4'h0);
    t_sync(4'h5, 4'h2);
    t_pd();
    t_entry(1'h0, CPDED_C * LINK_C - 8, CPDED_C * LINK_C + 8);
    t_entry(1'h1, 100, 200);
    t_lead();
    stop_test();
  end
endmodule : tb
